// *** pgra_consts.svh ***
/*
  constants of the bus request/grant arbiter: requester indices, priority
  modes and the idle value of the five grant outputs.
  assumes inclusion by bare name from the arbiter sources.
*/
`ifndef PGRA_CONSTS_SVH
`define PGRA_CONSTS_SVH
`define PGRA_NUM_REQ 5
`define PGRA_IDX_HOST 0
`define PGRA_IDX_INIT0 1
`define PGRA_IDX_INIT1 2
`define PGRA_IDX_INIT2 3
`define PGRA_IDX_INIT3 4
`define PGRA_MODE_FIXED 2'h0
`define PGRA_MODE_ROTATE 2'h1
`define PGRA_MODE_MIXED 2'h2
`define PGRA_GNT_IDLE 5'h1f
`endif

// *** pgra_pkg.sv ***
/*
  types of the bus request/grant arbiter.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none
package pgra_pkg;
  typedef enum logic [2:0] {
    PGRA_RESET = 3'b001,
    PGRA_IDLE = 3'b010,
    PGRA_OWNED = 3'b100
  } pgra_state_t;
endpackage
`default_nettype wire

// *** pgra_pick.sv ***
/*
  combinational winner picker: fixed, rotating or mixed priority over
  active-high requests; one-hot result.
  assumes the caller registers the result.
*/
`include "pgra_consts.svh"
`default_nettype none
module pgra_pick #(
  parameter int N = `PGRA_NUM_REQ
) (
  input wire logic [N-1:0] req,
  input wire logic [1:0] mode,
  input wire logic [N-1:0] last,
  output logic [N-1:0] win
);
  // rotate start past the last owner; mixed keeps host first, rotates the rest
  function automatic logic [N-1:0] pick_from(input logic [N-1:0] r,
                                             input logic [N-1:0] l);
    logic [2*N-1:0] dbl;
    logic [N-1:0] res;
    int s;
    int k;
    dbl = '0;
    res = '0;
    s = 0;
    for (k = 0; k < N; k++) begin
      if (l[k]) begin
        s = k + 1;
      end
    end
    dbl = {r, r};
    for (k = 2 * N - 1; k >= 0; k--) begin
      if (k >= s && k < s + N && dbl[k]) begin
        res = '0;
        res[k % N] = 1'b1;
      end
    end
    return res;
  endfunction

  wire logic [N-1:0] fixed_win = req & (~req + {{(N-1){1'b0}}, 1'b1});
  wire logic [N-1:0] rot_win = pick_from(req, last);
  wire logic [N-1:0] mix_win = req[0] ? {{(N-1){1'b0}}, 1'b1} :
                                        pick_from(req, last);
  assign win = (mode == `PGRA_MODE_ROTATE) ? rot_win :
               (mode == `PGRA_MODE_MIXED) ? mix_win : fixed_win;
endmodule // pgra_pick
`default_nettype wire

// *** pgra_arbiter.sv ***
/*
  bus request/grant arbiter of the bridge, with strap-selected internal or
  external arbitration and system-error to nmi.
  assumes all inputs synchronous to clk; arst_n follows the bus reset.
*/
// What this block does
// - enable arbiter if host request high at release
// - disable arbiter if host request low then
// - low host request is a pending request
// - config enable also decides request-1 use
// - request-0 pin: initiator request or external grant
// - ignore request 1 when arbiter disabled
// - drive host grant low to award bus
// - grant-0 pin: grant or request to external
// - grant-1 pin: grant or resume after retry
// - host grant undriven from reset start
// - grant 0 and 1 undriven from reset
// - grant follows scheme and current requests
// - drive grant 2 or 3 low to award
// - grants 2 and 3 high in reset
// - low system error raises nmi
`include "pgra_consts.svh"
`default_nettype none
module pgra_arbiter #(
  parameter int N = `PGRA_NUM_REQ
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_bus_request_n,
  input wire logic initiator0_request_n,
  input wire logic initiator1_request_n,
  input wire logic initiator2_request_n,
  input wire logic initiator3_request_n,
  input wire logic bus_frame_n,
  input wire logic bus_irdy_n,
  input wire logic cfg_arb_write,
  input wire logic cfg_arb_enable,
  input wire logic [1:0] cfg_prio_mode,
  input wire logic bridge_bus_need,
  input wire logic retry_cleared,
  input wire logic system_error_n,
  output logic host_bus_grant_n,
  output logic host_bus_grant_oe_n,
  output logic initiator0_grant_n,
  output logic initiator0_grant_oe_n,
  output logic initiator1_grant_n,
  output logic initiator1_grant_oe_n,
  output logic initiator2_grant_n,
  output logic initiator3_grant_n,
  output logic arb_enabled,
  output logic bridge_owns_bus,
  output logic nmi
);
  // the pin map below is written for the host plus four initiators
  if (N != `PGRA_NUM_REQ) begin : g_bad_n
    $error("pgra_arbiter serves exactly five requesters");
  end

  pgra_pkg::pgra_state_t state;
  pgra_pkg::pgra_state_t next_state;
  logic strap_pending;
  logic [1:0] mode;
  logic [N-1:0] grant;
  logic [N-1:0] last;
  logic [N-1:0] next_grant;
  logic next_arb_enabled;

  // active-low pin level of one slot of a grant vector
  function automatic logic grant_pin_n(input logic enabled, input logic [N-1:0] gv,
                                       input int idx);
    return ~(enabled & gv[idx]);
  endfunction

  // internal mode: low request pins are pending requests
  wire logic [N-1:0] req = {~initiator3_request_n, ~initiator2_request_n,
                            ~initiator1_request_n & arb_enabled,
                            ~initiator0_request_n,
                            ~host_bus_request_n};
  wire logic [N-1:0] win;
  wire logic bus_idle = bus_frame_n & bus_irdy_n;
  wire logic owner_keeps = |(grant & req);
  // regrant only when the owner has dropped its request and the bus is idle
  wire logic may_switch = ~owner_keeps & bus_idle;
  // external mode: request-0 pin carries the outside grant
  wire logic ext_granted = ~initiator0_request_n;

  pgra_pick #(.N(N)) u_pick (
    .req(req),
    .mode(mode),
    .last(last),
    .win(win)
  );

  always_comb begin
    next_state = state;
    next_grant = grant;
    case (state)
      pgra_pkg::PGRA_RESET: begin
        // the strap edge never grants
        next_state = pgra_pkg::PGRA_IDLE;
        next_grant = '0;
      end
      pgra_pkg::PGRA_IDLE: begin
        // a first grant waits for an idle bus
        if (arb_enabled && |req && bus_idle) begin
          next_grant = win;
          next_state = pgra_pkg::PGRA_OWNED;
        end
      end
      pgra_pkg::PGRA_OWNED: begin
        // arbiter switched off by config: drop the grant
        if (!arb_enabled) begin
          next_grant = '0;
          next_state = pgra_pkg::PGRA_IDLE;
        end else if (may_switch) begin
          next_grant = win;
          next_state = |req ? pgra_pkg::PGRA_OWNED : pgra_pkg::PGRA_IDLE;
        end
      end
      default: begin
        // illegal code: fall back to idle with no grant
        next_state = pgra_pkg::PGRA_IDLE;
        next_grant = '0;
      end
    endcase
  end

  // strap caught at the first edge after reset release, then config writes
  always_comb begin
    next_arb_enabled = arb_enabled;
    if (strap_pending) begin
      next_arb_enabled = host_bus_request_n;
    end else if (cfg_arb_write) begin
      next_arb_enabled = cfg_arb_enable;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_pending <= 1'b1;
      arb_enabled <= 1'b0;
    end else begin
      strap_pending <= 1'b0;
      arb_enabled <= next_arb_enabled;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pgra_pkg::PGRA_RESET;
      grant <= '0;
      last <= '0;
      mode <= `PGRA_MODE_FIXED;
      bridge_owns_bus <= 1'b0;
      nmi <= 1'b0;
    end else begin
      state <= next_state;
      grant <= next_grant;
      if (|next_grant) begin
        last <= next_grant;
      end
      if (cfg_arb_write) begin
        mode <= cfg_prio_mode;
      end
      bridge_owns_bus <= ~arb_enabled & ext_granted & ~strap_pending;
      if (!system_error_n) begin
        nmi <= 1'b1;
      end else begin
        nmi <= 1'b0;
      end
    end
  end

  // next pin levels follow the new mode, so a mode switch never shows stale pins
  wire logic next_host_grant_n = grant_pin_n(next_arb_enabled, next_grant,
                                             `PGRA_IDX_HOST);
  wire logic next_init0_grant_n = next_arb_enabled ?
                                  grant_pin_n(1'b1, next_grant, `PGRA_IDX_INIT0) :
                                  ~bridge_bus_need;
  wire logic next_init1_grant_n = next_arb_enabled ?
                                  grant_pin_n(1'b1, next_grant, `PGRA_IDX_INIT1) :
                                  ~retry_cleared;
  wire logic next_init2_grant_n = grant_pin_n(next_arb_enabled, next_grant,
                                              `PGRA_IDX_INIT2);
  wire logic next_init3_grant_n = grant_pin_n(next_arb_enabled, next_grant,
                                              `PGRA_IDX_INIT3);

  // pin drivers; shared pins undriven until the strap has been taken
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      host_bus_grant_n <= 1'b1;
      host_bus_grant_oe_n <= 1'b1;
      initiator0_grant_n <= 1'b1;
      initiator0_grant_oe_n <= 1'b1;
      initiator1_grant_n <= 1'b1;
      initiator1_grant_oe_n <= 1'b1;
      initiator2_grant_n <= 1'b1;
      initiator3_grant_n <= 1'b1;
    end else if (strap_pending) begin
      host_bus_grant_oe_n <= 1'b1;
      initiator0_grant_oe_n <= 1'b1;
      initiator1_grant_oe_n <= 1'b1;
    end else begin
      host_bus_grant_oe_n <= ~next_arb_enabled;
      initiator0_grant_oe_n <= 1'b0;
      initiator1_grant_oe_n <= 1'b0;
      host_bus_grant_n <= next_host_grant_n;
      initiator0_grant_n <= next_init0_grant_n;
      initiator1_grant_n <= next_init1_grant_n;
      initiator2_grant_n <= next_init2_grant_n;
      initiator3_grant_n <= next_init3_grant_n;
    end
  end

endmodule // pgra_arbiter
`default_nettype wire

// *** pgra_arbiter_checker.sv ***
/*
  port checker of the bus request/grant arbiter.
  assumes it is bound to pgra_arbiter and sees only its ports.
*/
`default_nettype none
module pgra_arbiter_checker #(parameter int N = 5) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic host_bus_request_n,
  input wire logic initiator2_request_n,
  input wire logic bridge_bus_need,
  input wire logic retry_cleared,
  input wire logic system_error_n,
  input wire logic host_bus_grant_n,
  input wire logic host_bus_grant_oe_n,
  input wire logic initiator0_grant_n,
  input wire logic initiator0_grant_oe_n,
  input wire logic initiator1_grant_n,
  input wire logic initiator1_grant_oe_n,
  input wire logic initiator2_grant_n,
  input wire logic initiator3_grant_n,
  input wire logic arb_enabled,
  input wire logic nmi
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire logic [4:0] g = {initiator3_grant_n, initiator2_grant_n, initiator1_grant_n,
    initiator0_grant_n, host_bus_grant_n};
  // reset already seen at the previous edge; the first edge of a reset is not judged
  logic rst_held = 1'b0;
  always @(posedge clk) rst_held <= !arst_n;
  AST_RST_QUIET: assert property (disable iff (1'b0) !arst_n && rst_held |-> &g[4:3] &&
    host_bus_grant_oe_n && initiator0_grant_oe_n && initiator1_grant_oe_n) else $error("reset out");
  AST_ONE_GRANT: assert property (arb_enabled |-> $countones(~g) <= 1)
    else $error("two grants");
  AST_STRAP: assert property ($rose(arst_n) |=> arb_enabled == $past(host_bus_request_n))
    else $error("strap");
  AST_HOST_GNT: assert property (arb_enabled && $fell(host_bus_grant_n) |->
    !$past(host_bus_request_n)) else $error("host grant");
  AST_INITIATOR2_GRANT_N: assert property (arb_enabled && $fell(initiator2_grant_n) |->
    !$past(initiator2_request_n)) else $error("grant 2");
  AST_OFF: assert property (!arb_enabled |=> arb_enabled || &g[4:3]) else $error("off");
  AST_EXT_REQ: assert property (!arb_enabled && !initiator0_grant_oe_n |=> arb_enabled ||
    initiator0_grant_n == !$past(bridge_bus_need)) else $error("bridge request");
  AST_EXT_RES: assert property (!arb_enabled && !initiator1_grant_oe_n |=> arb_enabled ||
    initiator1_grant_n == !$past(retry_cleared)) else $error("resume");
  AST_NMI: assert property (1'b1 |=> nmi == !$past(system_error_n)) else $error("nmi");
  cover property (arb_enabled && $fell(host_bus_grant_n));
  cover property (arb_enabled && $fell(initiator2_grant_n));
  cover property (nmi);
endmodule  // pgra_arbiter_checker
`default_nettype wire

// *** pgra_partner.sv ***
/*
  requester model: host and initiator request lines and bus activity.
  assumes the bench sets want; the owner holds the bus while it requests.
*/
`default_nettype none
module pgra_partner (
  input wire logic clk,
  input wire logic [4:0] want,
  input wire logic [4:0] grant_n,
  output logic [4:0] req_n,
  output logic frame_n,
  output logic irdy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  assign req_n = ~want;
  initial {frame_n, irdy_n} = 2'b11;
  always @(posedge clk) begin
    frame_n <= &(grant_n | req_n);
    irdy_n <= &(grant_n | req_n);
  end
endmodule  // pgra_partner
`default_nettype wire

// *** pgra_arbiter_tb.sv ***
/*
  self-checking bench of the arbiter with a scoreboard queue.
  assumes checker and partner files are compiled before it.
*/
`default_nettype none
module pgra_arbiter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, arst_n = 0, cfg_w = 0, cfg_en = 0, bneed = 0, rclr = 0, serr_n = 1;
  logic [1:0] mode = 2'h0;
  logic [4:0] want = 5'h00, prev = 5'h1f;
  logic [4:0] q[$];
  wire logic [4:0] req_n, g;
  wire logic frame_n, irdy_n, ho, oe0, oe1, en, own, nmi;
  int fail_count = 0, checks = 0, seed = 32'h82aa;
  pgra_arbiter dut_u (.clk, .arst_n, .host_bus_request_n(req_n[0]),
    .initiator0_request_n(req_n[1]), .initiator1_request_n(req_n[2]),
    .initiator2_request_n(req_n[3]), .initiator3_request_n(req_n[4]), .bus_frame_n(frame_n),
    .bus_irdy_n(irdy_n), .cfg_arb_write(cfg_w), .cfg_arb_enable(cfg_en), .cfg_prio_mode(mode),
    .bridge_bus_need(bneed), .retry_cleared(rclr), .system_error_n(serr_n),
    .host_bus_grant_n(g[0]), .host_bus_grant_oe_n(ho), .initiator0_grant_n(g[1]),
    .initiator0_grant_oe_n(oe0), .initiator1_grant_n(g[2]), .initiator1_grant_oe_n(oe1),
    .initiator2_grant_n(g[3]), .initiator3_grant_n(g[4]), .arb_enabled(en),
    .bridge_owns_bus(own), .nmi);
  pgra_partner pm_u (.clk, .want, .grant_n(g), .req_n, .frame_n, .irdy_n);
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rst(input logic strap);
    arst_n = 0;
    want = {4'h0, !strap};
    repeat (2) @(negedge clk);
    chk({g[4:3], ho, oe0, oe1}, 5'h1f);
    arst_n = 1;
    @(negedge clk);
    want = 5'h00;
    repeat (2) @(negedge clk);
    chk({4'h0, en}, {4'h0, strap});
  endtask
  task automatic cfg(input logic e, input logic [1:0] m);
    {cfg_en, mode, cfg_w} = {e, m, 1'b1};
    @(negedge clk);
    cfg_w = 1'b0;
  endtask
  // note the expected winner, then the other new requesters in order; request,
  // hold until granted, then release
  task automatic grant(input logic [4:0] w, input int i);
    int k;
    if (w[i]) q.push_back(~(5'h01 << i));
    for (k = 0; k < 5; k++) if (w[k] && k != i) q.push_back(~(5'h01 << k));
    want = want | w;
    for (k = 0; k < 20 && g[i] !== 1'b0; k++) @(negedge clk);
    want[i] = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (arst_n && en === 1'b1 && g !== prev && g !== 5'h1f) begin
      if (q.size() == 0) chk(g, 5'h1f);
      else chk(g, q.pop_front());
    end
    prev <= g;
  end
  initial begin
    forever #25 clk = ~clk;
  end
  initial begin
    #(50 * 4000);
    fail_count++;
    final_report();
  end
  initial begin
    int r;
    rst(1'b1);
    for (int m = 0; m < 3; m++) begin
      cfg(1'b1, m[1:0]);
      for (int i = 0; i < 5; i++) grant(5'h01 << i, i);
      r = $unsigned($random(seed)) % 5;
      grant(5'h01 << r, r);
    end
    grant(5'h11, 0);
    grant(5'h00, 4);
    serr_n = 0;
    @(negedge clk);
    chk({4'h0, nmi}, 5'h01);
    serr_n = 1;
    rst(1'b0);
    {bneed, rclr, want} = {2'b11, 5'h06};
    repeat (2) @(negedge clk);
    chk({g[3:1], own, ho}, 5'h13);
    {bneed, rclr, want} = 7'h00;
    cfg(1'b1, 2'h1);
    chk({4'h0, en}, 5'h01);
    grant(5'h08, 3);
    grant(5'h11, 4);
    grant(5'h00, 0);
    chk(5'(q.size()), 5'h00);
    final_report();
  end
endmodule  // pgra_arbiter_tb
bind pgra_arbiter pgra_arbiter_checker #(.N(N)) chk_u (.clk, .arst_n, .host_bus_request_n,
  .initiator2_request_n, .bridge_bus_need, .retry_cleared, .system_error_n, .host_bus_grant_n,
  .host_bus_grant_oe_n, .initiator0_grant_n, .initiator0_grant_oe_n, .initiator1_grant_n,
  .initiator1_grant_oe_n, .initiator2_grant_n, .initiator3_grant_n, .arb_enabled, .nmi);
`default_nettype wire
